// ### dbm_pkg.sv
// Purpose: Shared constants for the delay buffer memory interface
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Access lengths are counted in pclk cycles
package dbm_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 24;
  localparam int CNT_W  = 5;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_BASE   = 8'h08;
  localparam logic [7:0] OFF_ROFF   = 8'h0C;
  localparam logic [7:0] OFF_WDATA  = 8'h10;
  localparam logic [7:0] OFF_RDATA  = 8'h14;
  localparam logic [7:0] OFF_REFR   = 8'h18;

  // Control register fields
  localparam int CTRL_RINC  = 0;
  localparam int CTRL_WINC  = 1;
  localparam int CTRL_DRAM  = 2;
  localparam int CTRL_DTS   = 3;
  localparam int CTRL_SWS_L = 4;
  localparam int CTRL_W     = 8;
  localparam int REFR_W     = 16;

  // Status register fields
  localparam int STAT_BUSY  = 0;
  localparam int STAT_RFULL = 1;
  localparam int STAT_WEMPT = 2;
  localparam int STAT_RPEND = 3;
  localparam int STAT_WAIT  = 4;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [REFR_W-1:0] REFR_RST = 16'h0000;

  // Access lengths in cycles; pin data takes SYNC_LAT cycles to arrive
  localparam logic [CNT_W-1:0] SYNC_LAT      = 5'h02;
  localparam logic [CNT_W-1:0] ACC_DRAM_FAST = 5'h04;
  localparam logic [CNT_W-1:0] ACC_DRAM_SLOW = 5'h06;
  localparam logic [CNT_W-1:0] ACC_SRAM_BASE = 5'h02;

  typedef enum logic [0:0] {ST_IDLE, ST_ACCESS} dbm_state_e;
endpackage

// ### dbm_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Input may change at any time relative to pclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module dbm_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### dbm_ctrl.sv
// Purpose: Delay buffer memory interface with APB register access
// Assumes: pclk 20 MHz, presetn asynchronous active low
// Notes:   One word access per trigger; write pending beats read pending
//
// How it works
// - Core wait does not stall the engine; started accesses finish.
// - Idle engine starts only on a new read or write trigger.
// - Wait changes no control, status or refresh register bit.
// - Read address is base pointer minus tap offset.
// - Each write to the tap offset register launches one read.
// - Base pointer stays put after reads when read increment is 0.
// - With write increment set, data goes to base, then base+1.
// - In DRAM mode timing select 0 is fast, 1 is slow.
`timescale 1ns/1ps
module dbm_ctrl (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       core_wait,
  output logic      [dbm_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [dbm_pkg::DATA_W-1:0] mem_data_i,
  output logic      [dbm_pkg::DATA_W-1:0] mem_data_o,
  output logic                            mem_data_oe_n,
  output logic                            mem_ce_n,
  output logic                            mem_we_n,
  output logic                            mem_oe_n
);
  typedef struct packed {
    dbm_pkg::dbm_state_e                st;
    logic [dbm_pkg::CTRL_W-1:0]         ctrl;
    logic [dbm_pkg::REFR_W-1:0]         refr;
    logic [dbm_pkg::ADDR_W-1:0]         base;
    logic [dbm_pkg::ADDR_W-1:0]         roff;
    logic [dbm_pkg::DATA_W-1:0]         wdata;
    logic [dbm_pkg::DATA_W-1:0]         rdata;
    logic                               rd_pend;
    logic                               wr_pend;
    logic                               rd_full;
    logic                               is_wr;
    logic [dbm_pkg::CNT_W-1:0]          cnt;
    logic [dbm_pkg::ADDR_W-1:0]         addr;
    logic [dbm_pkg::DATA_W-1:0]         dout;
  } dbm_regs_s;

  dbm_regs_s s_q;
  dbm_regs_s s_d;

  logic                        wait_s;
  logic [dbm_pkg::DATA_W-1:0]  mem_data_s;
  logic                        apb_acc;
  logic                        apb_wr;
  logic                        mapped;
  logic [dbm_pkg::CNT_W-1:0]   acc_len;
  logic                        acc_done;

  dbm_sync #(.W(1)) u_wait_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (core_wait),
    .q       (wait_s)
  );

  dbm_sync #(.W(dbm_pkg::DATA_W)) u_data_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (mem_data_i),
    .q       (mem_data_s)
  );

  assign apb_acc  = psel && penable;
  assign apb_wr   = apb_acc && pwrite;
  assign acc_done = (s_q.st == dbm_pkg::ST_ACCESS) && (s_q.cnt == '0);
  assign mapped   = (paddr == dbm_pkg::OFF_CTRL)  ||
                    (paddr == dbm_pkg::OFF_STATUS) ||
                    (paddr == dbm_pkg::OFF_BASE)  ||
                    (paddr == dbm_pkg::OFF_ROFF)  ||
                    (paddr == dbm_pkg::OFF_WDATA) ||
                    (paddr == dbm_pkg::OFF_RDATA) ||
                    (paddr == dbm_pkg::OFF_REFR);

  always_comb begin
    if (s_q.ctrl[dbm_pkg::CTRL_DRAM]) begin
      acc_len = s_q.ctrl[dbm_pkg::CTRL_DTS] ? dbm_pkg::ACC_DRAM_SLOW
                                            : dbm_pkg::ACC_DRAM_FAST;
    end else begin
      acc_len = dbm_pkg::ACC_SRAM_BASE +
                {1'b0, s_q.ctrl[dbm_pkg::CTRL_SWS_L +: 4]};
    end
  end

  always_comb begin
    s_d = s_q;
    // Reading the data register empties it; a fresh capture below wins
    if (apb_acc && !pwrite && paddr == dbm_pkg::OFF_RDATA) begin
      s_d.rd_full = 1'b0;
    end
    // engine keeps counting whatever the core wait level
    case (s_q.st)
      dbm_pkg::ST_IDLE: begin
        // start only on a pending trigger
        if (s_q.wr_pend) begin
          s_d.st      = dbm_pkg::ST_ACCESS;
          s_d.is_wr   = 1'b1;
          s_d.wr_pend = 1'b0;
          s_d.addr    = s_q.base;
          s_d.dout    = s_q.wdata;
          s_d.cnt     = acc_len;
        end else if (s_q.rd_pend) begin
          s_d.st      = dbm_pkg::ST_ACCESS;
          s_d.is_wr   = 1'b0;
          s_d.rd_pend = 1'b0;
          s_d.addr    = s_q.base - s_q.roff;
          s_d.cnt     = acc_len + dbm_pkg::SYNC_LAT;
        end
      end
      dbm_pkg::ST_ACCESS: begin
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 1'b1;
        end else begin
          s_d.st = dbm_pkg::ST_IDLE;
          if (s_q.is_wr) begin
            if (s_q.ctrl[dbm_pkg::CTRL_WINC]) begin
              s_d.base = s_q.base + 1'b1;
            end
          end else begin
            s_d.rdata   = mem_data_s;
            s_d.rd_full = 1'b1;
            // base held unless read increment set
            if (s_q.ctrl[dbm_pkg::CTRL_RINC]) begin
              s_d.base = s_q.base + 1'b1;
            end
          end
        end
      end
      default: s_d.st = dbm_pkg::ST_IDLE;
    endcase
    // Software writes come last so a trigger beats a same-cycle clear
    if (apb_wr) begin
      case (paddr)
        dbm_pkg::OFF_CTRL: s_d.ctrl = pwdata[dbm_pkg::CTRL_W-1:0];
        dbm_pkg::OFF_REFR: s_d.refr = pwdata[dbm_pkg::REFR_W-1:0];
        dbm_pkg::OFF_BASE: s_d.base = pwdata[dbm_pkg::ADDR_W-1:0];
        dbm_pkg::OFF_ROFF: begin
          s_d.roff    = pwdata[dbm_pkg::ADDR_W-1:0];
          s_d.rd_pend = 1'b1;
        end
        dbm_pkg::OFF_WDATA: begin
          s_d.wdata   = pwdata[dbm_pkg::DATA_W-1:0];
          s_d.wr_pend = 1'b1;
        end
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end
  end

  // wait level is never an input to any register here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.st   <= dbm_pkg::ST_IDLE;
      s_q.ctrl <= dbm_pkg::CTRL_RST;
      s_q.refr <= dbm_pkg::REFR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      dbm_pkg::OFF_CTRL:   prdata[dbm_pkg::CTRL_W-1:0] = s_q.ctrl;
      dbm_pkg::OFF_REFR:   prdata[dbm_pkg::REFR_W-1:0] = s_q.refr;
      dbm_pkg::OFF_BASE:   prdata[dbm_pkg::ADDR_W-1:0] = s_q.base;
      dbm_pkg::OFF_ROFF:   prdata[dbm_pkg::ADDR_W-1:0] = s_q.roff;
      dbm_pkg::OFF_WDATA:  prdata[dbm_pkg::DATA_W-1:0] = s_q.wdata;
      dbm_pkg::OFF_RDATA:  prdata[dbm_pkg::DATA_W-1:0] = s_q.rdata;
      dbm_pkg::OFF_STATUS: begin
        prdata[dbm_pkg::STAT_BUSY]  = (s_q.st == dbm_pkg::ST_ACCESS);
        prdata[dbm_pkg::STAT_RFULL] = s_q.rd_full;
        prdata[dbm_pkg::STAT_WEMPT] = !s_q.wr_pend;
        prdata[dbm_pkg::STAT_RPEND] = s_q.rd_pend;
        // wait level kept out of status, so Wait flips no bit
        prdata[dbm_pkg::STAT_WAIT]  = 1'b0;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  assign pready        = 1'b1;
  assign pslverr       = apb_acc && !mapped;
  assign mem_addr      = s_q.addr;
  assign mem_data_o    = s_q.dout;
  assign mem_ce_n      = (s_q.st != dbm_pkg::ST_ACCESS);
  assign mem_we_n      = !((s_q.st == dbm_pkg::ST_ACCESS) && s_q.is_wr);
  assign mem_oe_n      = !((s_q.st == dbm_pkg::ST_ACCESS) && !s_q.is_wr);
  assign mem_data_oe_n = mem_we_n;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic base_wr;
  assign base_wr = apb_wr && (paddr == dbm_pkg::OFF_BASE);

  wait_progress_a: assert property (
    (s_q.st == dbm_pkg::ST_ACCESS && s_q.cnt != '0 && wait_s)
    |=> s_q.cnt == $past(s_q.cnt) - 5'h01 && !mem_ce_n)
    else $error("access stalled during core wait");

  idle_hold_a: assert property (
    (s_q.st == dbm_pkg::ST_IDLE && !s_q.rd_pend && !s_q.wr_pend)
    |=> mem_ce_n)
    else $error("access started with no trigger");

  wait_regs_a: assert property (
    ($changed(wait_s) && !apb_wr)
    |=> $stable(s_q.ctrl) && $stable(s_q.refr))
    else $error("wait changed control bits");

  tap_addr_a: assert property (
    (s_q.st == dbm_pkg::ST_IDLE && !s_q.wr_pend && s_q.rd_pend)
    |=> mem_addr == $past(s_q.base) - $past(s_q.roff) && !mem_oe_n)
    else $error("tap address wrong");

  read_launch_a: assert property (
    (apb_wr && paddr == dbm_pkg::OFF_ROFF) |=> s_q.rd_pend)
    else $error("offset write did not launch read");

  base_hold_a: assert property (
    (acc_done && !s_q.is_wr && !s_q.ctrl[dbm_pkg::CTRL_RINC] && !base_wr)
    |=> $stable(s_q.base))
    else $error("base moved after read");

  write_inc_a: assert property (
    (acc_done && s_q.is_wr && s_q.ctrl[dbm_pkg::CTRL_WINC] && !base_wr)
    |=> s_q.base == $past(s_q.base) + 20'h0_0001)
    else $error("base not incremented after write");

  dram_len_a: assert property (
    (s_q.st == dbm_pkg::ST_IDLE && s_q.wr_pend &&
     s_q.ctrl[dbm_pkg::CTRL_DRAM])
    |=> s_q.cnt == ($past(s_q.ctrl[dbm_pkg::CTRL_DTS]) ? 5'h06 : 5'h04))
    else $error("DRAM access length wrong");

  sram_len_a: assert property (
    (s_q.st == dbm_pkg::ST_IDLE && s_q.wr_pend &&
     !s_q.ctrl[dbm_pkg::CTRL_DRAM])
    |=> s_q.cnt == 5'h02 + {1'b0, $past(s_q.ctrl[7:4])})
    else $error("SRAM access length wrong");

  cov_read_c:  cover property (acc_done && !s_q.is_wr);
  cov_write_c: cover property (acc_done && s_q.is_wr &&
                               s_q.ctrl[dbm_pkg::CTRL_WINC]);
  cov_wait_c:  cover property (wait_s && acc_done);
  cov_pipe_c:  cover property (acc_done && (s_q.rd_pend || s_q.wr_pend));
endmodule

// ### dbm_mem_model.sv
// Purpose: Word memory standing on the far side of the interface
// Assumes: Active low strobes, one word per access, no pull on data
// Notes:   DLY holds back read data to mimic a slow part
`timescale 1ns/1ps
module dbm_mem_model #(
  parameter int DLY = 0
) (
  input  wire logic        pclk,
  input  wire logic        mem_ce_n,
  input  wire logic        mem_we_n,
  input  wire logic        mem_oe_n,
  input  wire logic        mem_data_oe_n,
  input  wire logic [19:0] mem_addr,
  input  wire logic [23:0] mem_data_o,
  output logic      [23:0] mem_data_i
);
  logic [23:0] mem [int];
  logic [23:0] last;
  int          rd_cnt;
  initial begin
    last = 24'h00_0000;
    rd_cnt = 0;
    mem_data_i = 24'hFF_FFFF;
  end
  always @(posedge pclk) begin
    // Data lands only while the controller really drives the bus
    if (!mem_ce_n && !mem_we_n && !mem_data_oe_n)
      mem[mem_addr] = mem_data_o;
    rd_cnt = (!mem_ce_n && !mem_oe_n) ? rd_cnt + 1 : 0;
    // Released bus shows the inverse, so a stale word never passes
    // A controller still driving during a read fights the part
    if (rd_cnt > DLY && mem_data_oe_n) begin
      last = mem.exists(mem_addr) ? mem[mem_addr] : {4'h0, mem_addr};
      mem_data_i <= last;
    end else
      mem_data_i <= ~last;
  end
endmodule

// ### delay_buffer_memory_interface_tb.sv
// Purpose: Self-checking bench for the delay buffer memory interface
// Assumes: Zero wait APB slave, memory model on the pins
// Notes:   Random data from a fixed LFSR seed
`timescale 1ns/1ps
module delay_buffer_memory_interface_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        core_wait, mem_data_oe_n, mem_ce_n, mem_we_n, mem_oe_n;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, ctrl, refr;
  logic [19:0] mem_addr, base;
  logic [23:0] mem_data_i, mem_data_o;
  logic [23:0] sh [int];
  int          n_mismatch, check_count, i, m;

  dbm_ctrl dbm_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_wait(core_wait), .mem_addr(mem_addr), .mem_data_i(mem_data_i),
    .mem_data_o(mem_data_o), .mem_data_oe_n(mem_data_oe_n),
    .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n));
  dbm_mem_model dbm_mem_model_i (.pclk(pclk), .mem_ce_n(mem_ce_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_addr(mem_addr),
    .mem_data_o(mem_data_o), .mem_data_i(mem_data_i),
    .mem_data_oe_n(mem_data_oe_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Cycles of chip enable low for one access
  function automatic int alen(input logic [31:0] c, input logic r);
    int l;
    l = c[2] ? (c[3] ? 6 : 4) : 2 + c[7:4];
    return l + 1 + (r ? 2 : 0);
  endfunction
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic acc(input int exp_ce);
    int n, ce;
    n = 0;
    ce = 0;
    while (mem_ce_n !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    while (mem_ce_n === 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
      ce++;
    end
    if (n >= 100 || ce == 0) begin
      n_mismatch++;
      final_report();
    end
    chk(ce, exp_ce);
  endtask
  task automatic wr(input logic [19:0] a);
    seed = lfsr(seed);
    sh[a] = seed[23:0];
    apb(1'b1, dbm_pkg::OFF_WDATA, {8'h00, seed[23:0]});
    acc(alen(ctrl, 1'b0));
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, core_wait} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seed = 32'h0001_4B50;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dbm_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    for (m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      ctrl = {24'h00_0000, (m == 3) ? 4'hF : seed[7:4], m == 2,
              m == 1 || m == 2, 2'b10};
      base = seed[19:0];
      apb(1'b1, dbm_pkg::OFF_CTRL, ctrl);
      apb(1'b1, dbm_pkg::OFF_BASE, {12'h000, base});
      for (i = 0; i < 4; i++)
        wr(20'(base + i));
      apb(1'b0, dbm_pkg::OFF_BASE, 32'h0000_0000);
      chk(rd, {12'h000, 20'(base + 4)});
      apb(1'b1, dbm_pkg::OFF_BASE, {12'h000, base ^ 20'h8_0000});
      wr(base ^ 20'h8_0000);
      apb(1'b1, dbm_pkg::OFF_BASE, {12'h000, 20'(base + 4)});
      for (i = 0; i < 3; i++) begin
        seed = lfsr(seed);
        apb(1'b1, dbm_pkg::OFF_ROFF, {30'h0, seed[1:0]} + 1);
        acc(alen(ctrl, 1'b1));
        apb(1'b0, dbm_pkg::OFF_RDATA, 32'h0000_0000);
        chk(rd, {8'h00, sh[20'(base + 3 - seed[1:0])]});
      end
      apb(1'b0, dbm_pkg::OFF_BASE, 32'h0000_0000);
      chk(rd, {12'h000, 20'(base + 4)});
    end
    seed = lfsr(seed);
    refr = {16'h0000, seed[15:0]};
    apb(1'b1, dbm_pkg::OFF_REFR, refr);
    seed = lfsr(seed);
    sh[20'(base + 4)] = seed[23:0];
    apb(1'b1, dbm_pkg::OFF_WDATA, {8'h00, seed[23:0]});
    // wait rises while the write is still under way
    core_wait <= 1'b1;
    acc(alen(ctrl, 1'b0));
    i = 0;
    repeat (20) begin
      @(posedge pclk);
      if (mem_ce_n !== 1'b1)
        i++;
    end
    chk(i, 0);
    apb(1'b0, dbm_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    apb(1'b0, dbm_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd, ctrl);
    apb(1'b0, dbm_pkg::OFF_REFR, 32'h0000_0000);
    chk(rd, refr);
    core_wait <= 1'b0;
    apb(1'b1, dbm_pkg::OFF_ROFF, 32'h0000_0001);
    acc(alen(ctrl, 1'b1));
    apb(1'b0, dbm_pkg::OFF_RDATA, 32'h0000_0000);
    chk(rd, {8'h00, sh[20'(base + 4)]});
    final_report();
  end
endmodule
